//--- design/pmp_seq.sv
// pattern playback sequencer with external real-time data path
`timescale 1ns/1ps
module pmp_seq #(
  parameter int unsigned DEPTH = pmp_pkg::MEM_DEPTH,
  parameter int unsigned BIT_DIV = pmp_pkg::BIT_DIV
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // download from host
  input wire logic dl_start,
  input wire logic dl_valid,
  input wire logic [7:0] dl_byte,
  input wire logic dl_end,
  output logic dl_busy,
  output logic [7:0] dl_error,
  output logic dl_error_valid,
  // playback control
  input wire logic play_enable,
  input wire logic ext_select,
  // external real-time source
  input wire logic ext_data,
  input wire logic ext_data_clock,
  input wire logic ext_symbol_sync,
  input wire logic burst_gate_input,
  input wire logic burst_gate_enable,
  // modulation outputs
  output logic mod_data,
  output logic mod_data_valid,
  output logic rf_gate,
  output logic event_pulse_output,
  output logic symbol_sync_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned DW = $clog2(BIT_DIV + 1);

  // playback address wraps at 2**AW, so depth must be a power of two
  if (DEPTH < pmp_pkg::MIN_BYTES || BIT_DIV < 2 ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_params
    $error("pmp_seq: unsupported DEPTH or BIT_DIV");
  end

  pmp_pkg::pmp_state_t state_q;
  logic [AW:0] wr_cnt_q;
  logic [AW-1:0] rd_addr_q;
  logic [DW-1:0] div_q;
  logic pattern_ok_q;
  logic overflow_q;
  logic [7:0] rd_data;
  logic bit_tick;
  logic fetch;
  logic ext_clk_d_q;
  logic ext_edge;
  logic wr_ok;

  // byte stays accepted only while memory has room
  assign wr_ok = (state_q == pmp_pkg::PMP_LOAD) && dl_valid &&
                 (wr_cnt_q < (AW+1)'(DEPTH));
  assign dl_busy = (state_q == pmp_pkg::PMP_LOAD);

  pmp_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .mclk(mclk),
    .wr_en(wr_ok),
    .wr_addr(wr_cnt_q[AW-1:0]),
    .wr_data(dl_byte),
    .rd_en(fetch),
    .rd_addr(rd_addr_q),
    .rd_data(rd_data)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= pmp_pkg::PMP_IDLE;
    end else begin
      unique case (state_q)
        pmp_pkg::PMP_IDLE: begin
          if (dl_start) begin
            state_q <= pmp_pkg::PMP_LOAD;
          end else if (play_enable && pattern_ok_q && !ext_select) begin
            state_q <= pmp_pkg::PMP_PLAY;
          end
        end
        pmp_pkg::PMP_LOAD: begin
          if (dl_end) begin
            state_q <= pmp_pkg::PMP_IDLE;
          end
        end
        pmp_pkg::PMP_PLAY: begin
          if (dl_start) begin
            state_q <= pmp_pkg::PMP_LOAD;
          end else if (!play_enable || ext_select) begin
            state_q <= pmp_pkg::PMP_IDLE;
          end
        end
        default: state_q <= pmp_pkg::PMP_IDLE;
      endcase
    end
  end

  // download byte counter and oversize detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_cnt_q <= '0;
      overflow_q <= 1'b0;
    end else if (state_q != pmp_pkg::PMP_LOAD && dl_start) begin
      wr_cnt_q <= '0;
      overflow_q <= 1'b0;
    end else if (state_q == pmp_pkg::PMP_LOAD && dl_valid) begin
      if (wr_ok) begin
        wr_cnt_q <= wr_cnt_q + (AW+1)'(1);
      end else begin
        overflow_q <= 1'b1;
      end
    end
  end

  // completion verdict; a rejected pattern is never played
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pattern_ok_q <= 1'b0;
      dl_error <= pmp_pkg::ERR_NONE;
      dl_error_valid <= 1'b0;
    end else begin
      dl_error_valid <= 1'b0;
      if (state_q != pmp_pkg::PMP_LOAD && dl_start) begin
        pattern_ok_q <= 1'b0;
      end else if (state_q == pmp_pkg::PMP_LOAD && dl_end) begin
        dl_error_valid <= 1'b1;
        if (overflow_q || (dl_valid && !wr_ok)) begin
          dl_error <= pmp_pkg::ERR_TOO_MUCH;
          pattern_ok_q <= 1'b0;
        end else if (wr_cnt_q + (AW+1)'(wr_ok) <
                     (AW+1)'(pmp_pkg::MIN_BYTES)) begin
          // short patterns are refused rather than replayed wrongly
          dl_error <= pmp_pkg::ERR_TOO_SHORT;
          pattern_ok_q <= 1'b0;
        end else begin
          dl_error <= pmp_pkg::ERR_NONE;
          pattern_ok_q <= 1'b1;
        end
      end
    end
  end

  // bit period divider; one tick per payload bit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_q <= '0;
    end else if (state_q != pmp_pkg::PMP_PLAY) begin
      div_q <= '0;
    end else if (div_q == DW'(BIT_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  assign bit_tick = (state_q == pmp_pkg::PMP_PLAY) &&
                    (div_q == DW'(BIT_DIV - 1));
  // fetch the next byte early so it is ready at the tick
  assign fetch = (state_q == pmp_pkg::PMP_PLAY) && (div_q == '0);

  // address sequencing
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_addr_q <= '0;
    end else if (state_q != pmp_pkg::PMP_PLAY) begin
      rd_addr_q <= '0;
    end else if (bit_tick) begin
      if (rd_data[pmp_pkg::BIT_RESTART]) begin
        rd_addr_q <= '0;
      end else begin
        // without a restart byte the address wraps over old contents
        rd_addr_q <= rd_addr_q + AW'(1);
      end
    end
  end

  // external clock edge detect; inputs are synchronous to mclk
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ext_clk_d_q <= 1'b0;
    end else begin
      ext_clk_d_q <= ext_data_clock;
    end
  end
  assign ext_edge = ext_data_clock && !ext_clk_d_q;

  // output stage: all fields of a byte applied at one tick
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mod_data <= 1'b0;
      mod_data_valid <= 1'b0;
      rf_gate <= 1'b0;
      event_pulse_output <= 1'b0;
      symbol_sync_out <= 1'b0;
    end else if (ext_select && play_enable) begin
      event_pulse_output <= 1'b0;
      mod_data_valid <= ext_edge;
      if (ext_edge) begin
        mod_data <= ext_data;
        symbol_sync_out <= ext_symbol_sync;
        // gate frames the stream only when enabled
        rf_gate <= burst_gate_enable ? burst_gate_input : 1'b1;
      end
    end else if (bit_tick) begin
      mod_data_valid <= rd_data[pmp_pkg::BIT_BURST];
      // payload forced low in off slots since it is unspecified there
      mod_data <= rd_data[pmp_pkg::BIT_DATA] &
                  rd_data[pmp_pkg::BIT_BURST];
      rf_gate <= rd_data[pmp_pkg::BIT_BURST];
      event_pulse_output <= rd_data[pmp_pkg::BIT_EVENT];
      symbol_sync_out <= 1'b1;
    end else begin
      // single-cycle event pulse per flagged byte
      event_pulse_output <= 1'b0;
      mod_data_valid <= 1'b0;
      symbol_sync_out <= 1'b0;
      if (state_q != pmp_pkg::PMP_PLAY && !ext_select) begin
        rf_gate <= 1'b0;
      end
    end
  end
endmodule // pmp_seq

//--- design/pmp_pkg.sv
// constants and layouts for the pattern memory playback sequencer
// Behaviour
// - bit0 payload, bits1-7 control, fixed reserved values
// - bit0 drives modulation, ignored when burst low
// - bit2 gates rf output on or off
// - bit6 set emits one event pulse
// - bit7 set restarts playback at address zero
// - oversize download rejected with too much data error
// - external serial data with clock and sync
// - external burst gate frames external data, else continuous
package pmp_pkg;
  localparam int unsigned BIT_DATA = 0;
  localparam int unsigned BIT_RSV1 = 1;
  localparam int unsigned BIT_BURST = 2;
  localparam int unsigned BIT_RSV3 = 3;
  localparam int unsigned BIT_RSV4 = 4;
  localparam int unsigned BIT_RSV5 = 5;
  localparam int unsigned BIT_EVENT = 6;
  localparam int unsigned BIT_RESTART = 7;
  localparam int unsigned MIN_BYTES = 60;
  localparam int unsigned MEM_DEPTH = 1024;
  localparam int unsigned BIT_DIV = 4;
  // magnitude of the too-much-data code -223; its sign does not fit 8 bits
  localparam logic [7:0] ERR_TOO_MUCH = 8'hDF;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_TOO_SHORT = 8'h01;
  typedef enum logic [2:0] {
    PMP_IDLE = 3'b001,
    PMP_LOAD = 3'b010,
    PMP_PLAY = 3'b100
  } pmp_state_t;
endpackage

//--- design/pmp_mem.sv
// pattern byte store with separate write and read ports and registered read data
`timescale 1ns/1ps
module pmp_mem #(
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned AW = 10
) (
  // clock
  input wire logic mclk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // pmp_mem

//--- testbench/pmp_seq_asserts.sv
// port checks for the playback sequencer
`timescale 1ns/1ps
module pmp_seq_asserts (
  // clock, reset and inputs
  input wire logic mclk,
  input wire logic reset,
  input wire logic dl_start,
  input wire logic dl_end,
  input wire logic ext_select,
  input wire logic play_enable,
  input wire logic ext_data_clock,
  // outputs
  input wire logic dl_busy,
  input wire logic dl_error_valid,
  input wire logic mod_data,
  input wire logic mod_data_valid,
  input wire logic rf_gate,
  input wire logic event_pulse_output,
  input wire logic symbol_sync_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_load_start: assert property (dl_start && !dl_busy |=> dl_busy)
    else $error("load not entered");
  a_end_answer: assert property (dl_busy && dl_end |=>
    !dl_busy && dl_error_valid) else $error("no download result");
  a_result_once: assert property (dl_error_valid |=> !dl_error_valid)
    else $error("result held too long");
  a_event_single: assert property (
    event_pulse_output |=> !event_pulse_output) else $error("event too long");
  a_payload_mask: assert property (
    symbol_sync_out && !ext_select && !rf_gate |-> !mod_data)
    else $error("payload not masked");
  a_valid_burst: assert property (
    mod_data_valid && !ext_select |-> rf_gate) else $error("valid, rf off");
  a_bit_period: assert property (
    symbol_sync_out && !ext_select |=> !symbol_sync_out [*3])
    else $error("bit period short");
  a_ext_answer: assert property (
    ext_select && play_enable && $rose(ext_data_clock) |-> ##[1:3]
    mod_data_valid)
    else $error("external bit lost");
endmodule // pmp_seq_asserts
bind pmp_seq pmp_seq_asserts i_asserts (.mclk(mclk), .reset(reset),
  .dl_start(dl_start), .dl_end(dl_end), .ext_select(ext_select),
  .play_enable(play_enable),
  .ext_data_clock(ext_data_clock), .dl_busy(dl_busy),
  .dl_error_valid(dl_error_valid), .mod_data(mod_data),
  .mod_data_valid(mod_data_valid), .rf_gate(rf_gate),
  .event_pulse_output(event_pulse_output),
  .symbol_sync_out(symbol_sync_out));

//--- testbench/pmp_host.sv
// host model that downloads pattern bytes
`timescale 1ns/1ps
module pmp_host (
  // clock
  input wire logic mclk,
  // download strobes
  output logic dl_start = 1'b0,
  output logic dl_valid = 1'b0,
  output logic [7:0] dl_byte = 8'h00,
  output logic dl_end = 1'b0
);
  // burst off only in byte 2, whose payload is 1, so masking is visible
  function automatic logic [7:0] bf(int i, int n);
    logic [7:0] b;
    b = 8'h10;
    b[0] = i[0] ^ i[1];
    b[2] = (i != 2);
    b[6] = (i % 5 == 0);
    b[7] = (i == n - 1);
    return b;
  endfunction
  task automatic load(int n);
    @(posedge mclk) dl_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      dl_start <= 1'b0;
      dl_valid <= 1'b1;
      dl_byte <= bf(i, n);
      dl_end <= (i == n - 1);
    end
    @(posedge mclk);
    dl_valid <= 1'b0;
    dl_end <= 1'b0;
    // released bus shows no stale byte
    dl_byte <= ~dl_byte;
  endtask
endmodule // pmp_host

//--- testbench/testbench.sv
// self-checking bench for the playback sequencer
`timescale 1ns/1ps
module testbench;
  logic mclk, reset, play_enable, ext_select, ext_data, ext_data_clock;
  logic ext_symbol_sync, burst_gate_input, burst_gate_enable;
  logic dl_start, dl_valid, dl_end, dl_busy, dl_error_valid, mod_data;
  logic mod_data_valid, rf_gate, event_pulse_output, symbol_sync_out;
  logic [7:0] dl_byte, dl_error;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  pmp_host i_host (.mclk(mclk), .dl_start(dl_start), .dl_valid(dl_valid),
    .dl_byte(dl_byte), .dl_end(dl_end));
  pmp_seq #(.DEPTH(64)) i_pmp_seq (.mclk(mclk), .reset(reset),
    .dl_start(dl_start), .dl_valid(dl_valid), .dl_byte(dl_byte),
    .dl_end(dl_end), .dl_busy(dl_busy), .dl_error(dl_error),
    .dl_error_valid(dl_error_valid), .play_enable(play_enable),
    .ext_select(ext_select), .ext_data(ext_data),
    .ext_data_clock(ext_data_clock), .ext_symbol_sync(ext_symbol_sync),
    .burst_gate_input(burst_gate_input),
    .burst_gate_enable(burst_gate_enable), .mod_data(mod_data),
    .mod_data_valid(mod_data_valid), .rf_gate(rf_gate),
    .event_pulse_output(event_pulse_output),
    .symbol_sync_out(symbol_sync_out));
  task automatic complete_run();
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic t_load(int n, logic [7:0] exp);
    i_host.load(n);
    @(negedge mclk);
    chk(8'(dl_error_valid), 8'h01);
    chk(dl_error, exp);
  endtask
  // 66 bits cross the restart byte and replay byte 0
  task automatic t_play();
    logic [7:0] b;
    int w;
    @(posedge mclk) play_enable <= 1'b1;
    for (int k = 0; k < 66; k++) begin
      b = i_host.bf(k % 60, 60);
      w = 0;
      do begin
        @(negedge mclk);
        w++;
      end while (symbol_sync_out !== 1'b1 && w < 12);
      chk(8'(rf_gate), 8'(b[2]));
      chk(8'(mod_data), 8'(b[0] & b[2]));
      chk(8'(event_pulse_output), 8'(b[6]));
      chk(8'(mod_data_valid), 8'(b[2]));
    end
    @(posedge mclk) play_enable <= 1'b0;
  endtask
  task automatic t_ext();
    logic [1:0] j;
    for (int i = 0; i < 4; i++) begin
      j = 2'(i);
      @(posedge mclk);
      ext_select <= 1'b1;
      play_enable <= 1'b1;
      ext_data <= j[0];
      burst_gate_enable <= j[1];
      burst_gate_input <= ~j[0];
      ext_symbol_sync <= j[0];
      @(posedge mclk) ext_data_clock <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk(8'(mod_data_valid), 8'h01);
      chk(8'(symbol_sync_out), 8'(j[0]));
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(8'(mod_data_valid), 8'h00);
      chk(8'(mod_data), 8'(j[0]));
      chk(8'(rf_gate), 8'(j[1] ? !j[0] : 1'b1));
      @(posedge mclk) ext_data_clock <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run needs about 500 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {reset, play_enable, ext_select, ext_data, ext_data_clock} = 5'h10;
    {ext_symbol_sync, burst_gate_input, burst_gate_enable} = 3'h0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_load(59, pmp_pkg::ERR_TOO_SHORT);
    t_load(65, pmp_pkg::ERR_TOO_MUCH);
    t_load(60, pmp_pkg::ERR_NONE);
    t_play();
    t_ext();
    complete_run();
  end
endmodule // testbench
